// ==== src/gcb_defines.svh ====
// Constants of the control board logic: regions, offsets, bit positions, reset values, timing
`ifndef GCB_DEFINES_SVH
`define GCB_DEFINES_SVH

// Address regions decoded from the three top address bits
`define GCB_REGION_PROGRAM 3'h7
`define GCB_REGION_SPARE 3'h6
`define GCB_REGION_ADAPTER 3'h5
`define GCB_REGION_BUS_CTRL 3'h4

// Bus interface controller functions, selected by the low three address bits
`define GCB_CTL_STATUS 3'h0
`define GCB_CTL_DATA 3'h1
`define GCB_CTL_ACK 3'h2

// Status bits of the bus interface controller
`define GCB_ST_AVAIL 0
`define GCB_ST_FULL 1
`define GCB_ST_REMOTE 2
`define GCB_ST_SERVICE 3
`define GCB_ST_SEQ 4

// Parallel adapter functions
`define GCB_PA_DATA_LO 3'h0
`define GCB_PA_DATA_HI 3'h1
`define GCB_PA_DIR_LO 3'h2
`define GCB_PA_DIR_HI 3'h3

// Parallel adapter line assignment
`define GCB_PA_SYN_LSB 0
`define GCB_PA_LOCK 4
`define GCB_PA_LEVELED 5
`define GCB_PA_WINDOW 6
`define GCB_PA_SPARE 7
`define GCB_PA_FREQ_LSB 8
`define GCB_PA_LEVEL_LSB 12

// Reset values and unmapped read data
`define GCB_PA_DIR_RST 16'h0000
`define GCB_PA_OUT_RST 16'h0000
`define GCB_UNMAPPED_DATA 8'hff

// Register map of the processor end on APB
`define GCB_REG_ADDR 12'h000
`define GCB_REG_WDATA 12'h004
`define GCB_REG_CTRL 12'h008
`define GCB_REG_STATUS 12'h00c
`define GCB_REG_RDATA 12'h010
`define GCB_CTRL_START 0
`define GCB_CTRL_READ 1

// Enable strobe length in clock cycles
`define GCB_E_CYCLES 2

`endif

// ==== src/gcb_pkg.sv ====
// Types shared by both ends of the control board logic
package gcb_pkg;
    typedef logic [15:0] gcb_addr_t;
    typedef logic [7:0] gcb_byte_t;

    // Three-wire acceptor handshake
    typedef enum logic [2:0] {
        HS_READY = 3'b001,
        HS_ACCEPT = 3'b010,
        HS_RELEASE = 3'b100
    } gcb_hs_e;

    // Processor bus cycle sequencer
    typedef enum logic [2:0] {
        M_IDLE = 3'b001,
        M_SETUP = 3'b010,
        M_ENABLE = 3'b100
    } gcb_cyc_e;
endpackage

// ==== src/gcb_proc_if.sv ====
// Processor-side bus joining the processor end and the board logic
`timescale 1ns/1ps
interface gcb_proc_if;
    logic [15:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic rw;
    logic e;
    logic valid_address_qualifier;
    logic irq_n;

    modport board (input addr, wdata, rw, e, valid_address_qualifier, output rdata, irq_n);
    modport processor (output addr, wdata, rw, e, valid_address_qualifier, input rdata, irq_n);
endinterface

// ==== src/gcb_fifo.sv ====
// Synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
module gcb_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin : g_bad
        $error("gcb_fifo: DEPTH must be a power of two of at least 2");
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wr_ptr_reg;
    logic [AW:0] rd_ptr_reg;
    logic push;
    logic pop;

    ////////////////////////////////////////////////////////////////////////////
    // Full when pointers differ only in the wrap bit
    assign o_in_ready = (wr_ptr_reg ^ rd_ptr_reg) != {1'b1, {AW{1'b0}}};
    assign o_out_valid = wr_ptr_reg != rd_ptr_reg;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;
    assign o_out_data = mem[rd_ptr_reg[AW-1:0]];

    // Storage, no reset needed
    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr_reg[AW-1:0]] <= i_in_data;
        end
    end

    // Pointers
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
        end
    end
endmodule

// ==== src/gcb_processor_end.sv ====
// Processor end: APB registers that run cycles on the processor-side bus
`timescale 1ns/1ps
`include "gcb_defines.svh"
module gcb_processor_end #(
    parameter int E_CYCLES = `GCB_E_CYCLES
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic I_PSEL,
    input wire logic I_PENABLE,
    input wire logic I_PWRITE,
    input wire logic [11:0] I_PADDR,
    input wire logic [31:0] I_PWDATA,
    output logic [31:0] O_PRDATA,
    output logic O_PREADY,
    output logic O_PSLVERR,
    gcb_proc_if.processor bus
);
    import gcb_pkg::*;

    if (E_CYCLES < 2 || E_CYCLES > 255) begin : g_bad
        $error("gcb_processor_end: E_CYCLES must be 2..255");
    end

    gcb_cyc_e state_reg;
    logic [7:0] e_cnt_reg;
    gcb_addr_t addr_reg;
    gcb_byte_t wdata_reg;
    gcb_byte_t rdata_reg;
    logic read_reg;
    logic done_reg;
    logic apb_wr;
    logic mapped;
    logic start;

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: zero wait states, error on unmapped offsets
    assign O_PREADY = 1'b1;
    assign mapped = I_PADDR == `GCB_REG_ADDR || I_PADDR == `GCB_REG_WDATA || I_PADDR == `GCB_REG_CTRL
        || I_PADDR == `GCB_REG_STATUS || I_PADDR == `GCB_REG_RDATA;
    assign O_PSLVERR = I_PSEL && I_PENABLE && !mapped;
    assign apb_wr = I_PSEL && I_PENABLE && I_PWRITE;
    // A start while a cycle runs is dropped; software polls busy first
    assign start = apb_wr && I_PADDR == `GCB_REG_CTRL && I_PWDATA[`GCB_CTRL_START] && state_reg == M_IDLE;

    // Read mux
    always_comb begin
        O_PRDATA = 32'h0000_0000;
        if (I_PADDR == `GCB_REG_ADDR) begin
            O_PRDATA = {16'h0000, addr_reg};
        end else if (I_PADDR == `GCB_REG_WDATA) begin
            O_PRDATA = {24'h00_0000, wdata_reg};
        end else if (I_PADDR == `GCB_REG_CTRL) begin
            O_PRDATA = {30'h0000_0000, read_reg, 1'b0};
        end else if (I_PADDR == `GCB_REG_STATUS) begin
            O_PRDATA = {29'h0000_0000, done_reg, !bus.irq_n, state_reg != M_IDLE};
        end else if (I_PADDR == `GCB_REG_RDATA) begin
            O_PRDATA = {24'h00_0000, rdata_reg};
        end
    end

    // Software-written cycle parameters
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            addr_reg <= 16'h0000;
            wdata_reg <= 8'h00;
            read_reg <= 1'b0;
        end else if (apb_wr && state_reg == M_IDLE) begin
            if (I_PADDR == `GCB_REG_ADDR) begin
                addr_reg <= I_PWDATA[15:0];
            end else if (I_PADDR == `GCB_REG_WDATA) begin
                wdata_reg <= I_PWDATA[7:0];
            end else if (I_PADDR == `GCB_REG_CTRL) begin
                read_reg <= I_PWDATA[`GCB_CTRL_READ];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus cycle: one setup cycle with address valid, then E high for E_CYCLES
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            state_reg <= M_IDLE;
            e_cnt_reg <= 8'h00;
            bus.valid_address_qualifier <= 1'b0;
            bus.e <= 1'b0;
            bus.rw <= 1'b1;
            bus.addr <= 16'h0000;
            bus.wdata <= 8'h00;
        end else begin
            case (state_reg)
                M_IDLE: begin
                    if (start) begin
                        state_reg <= M_SETUP;
                        bus.valid_address_qualifier <= 1'b1;
                        bus.addr <= addr_reg;
                        bus.rw <= I_PWDATA[`GCB_CTRL_READ];
                        bus.wdata <= wdata_reg;
                    end
                end
                M_SETUP: begin
                    state_reg <= M_ENABLE;
                    bus.e <= 1'b1;
                    e_cnt_reg <= 8'h01;
                end
                M_ENABLE: begin
                    if (e_cnt_reg == 8'(E_CYCLES)) begin
                        state_reg <= M_IDLE;
                        bus.e <= 1'b0;
                        bus.valid_address_qualifier <= 1'b0;
                        bus.rw <= 1'b1;
                    end else begin
                        e_cnt_reg <= e_cnt_reg + 8'h01;
                    end
                end
                default: begin
                    state_reg <= M_IDLE;
                end
            endcase
        end
    end

    // Read data taken on the last enable cycle; done flag
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_reg <= 8'h00;
            done_reg <= 1'b0;
        end else if (state_reg == M_ENABLE && e_cnt_reg == 8'(E_CYCLES)) begin
            done_reg <= 1'b1;
            if (bus.rw) begin
                rdata_reg <= bus.rdata;
            end
        end else if (start) begin
            done_reg <= 1'b0;
        end
    end
endmodule

// ==== src/gcb_board.sv ====
// Board logic: address decoder, bus interface controller and parallel adapter
`timescale 1ns/1ps
`include "gcb_defines.svh"

// What this block does
// - Eight data bits, sixteen address bits, memory-mapped
// - Read/write high reads, low writes; enable-timed
// - Decode top three bits with valid-address qualifier
// - Program memory select takes the top region
// - Only three low address bits reach peripherals
// - Controller runs three-wire handshake by itself
// - First service byte drives interrupt low, ack releases
// - Later bytes of sequence raise no interrupt
// - Lamp lights while interrupt is asserted
// - Software sets adapter six inputs, ten outputs
// - Inputs: four synthesizer address, lock, leveled
// - Processor reads synthesizer address and reports status
// - Transfer-window output governs synthesizer address sequence
// - Window low only while sending in remote; software sets line 6, and the logic does not gate it with remote
// - Outputs include four frequency, four level lines
module gcb_board #(
    parameter int FIFO_DEPTH = 16
) (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    gcb_proc_if.board bus,
    output logic O_PROGRAM_MEMORY_SELECT,
    output logic O_BUS_CONTROLLER_SELECT,
    output logic O_PARALLEL_ADAPTER_SELECT,
    output logic O_SPARE_ADAPTER_SELECT,
    output logic [12:0] O_PROG_ADDR,
    input wire gcb_pkg::gcb_byte_t I_PROG_DATA,
    input wire gcb_pkg::gcb_byte_t I_DIO,
    input wire logic I_DAV,
    input wire logic I_EOI,
    input wire logic I_REMOTE,
    output logic O_RFD,
    output logic O_DAC,
    output logic O_IRQ_LAMP,
    input wire logic [3:0] I_SYNTH_ADDR,
    input wire logic I_LOOP_LOCK,
    input wire logic I_LEVELED,
    output logic O_TRANSFER_WINDOW,
    output logic O_SPARE_OUT,
    output logic [3:0] O_FREQ_DATA,
    output logic [3:0] O_LEVEL_DATA
);
    import gcb_pkg::*;

    if (FIFO_DEPTH < 2) begin : g_bad
        $error("gcb_board: FIFO_DEPTH must be at least 2");
    end

    // One-hot strobe set for an address; all zero without the qualifier
    function automatic logic [3:0] region_sel(input logic qual, input logic [2:0] top);
        region_sel = 4'h0;
        if (qual) begin
            if (top == `GCB_REGION_PROGRAM) begin
                region_sel = 4'h1;
            end else if (top == `GCB_REGION_BUS_CTRL) begin
                region_sel = 4'h2;
            end else if (top == `GCB_REGION_ADAPTER) begin
                region_sel = 4'h4;
            end
        end
    endfunction

    logic [3:0] sel;
    logic [2:0] func;
    logic e_q_reg;
    logic access;
    logic rd_access;
    logic wr_access;
    gcb_byte_t rdata_reg;
    logic [12:0] prog_addr_reg;
    gcb_hs_e hs_reg;
    logic fifo_in_valid;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic fifo_pop;
    gcb_byte_t fifo_out_data;
    logic push;
    logic seq_reg;
    logic remote_q_reg;
    logic irq_reg;
    logic irq_set;
    logic irq_ack;
    logic [15:0] pa_out_reg;
    logic [15:0] pa_dir_reg;
    logic [15:0] pa_pins;
    logic [15:0] pa_read;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode and strobes
    assign sel = region_sel(bus.valid_address_qualifier, bus.addr[15:13]);
    assign func = bus.addr[2:0];
    assign O_PROGRAM_MEMORY_SELECT = sel[0];
    assign O_BUS_CONTROLLER_SELECT = sel[1];
    assign O_PARALLEL_ADAPTER_SELECT = sel[2];
    // Spare adapter is not fitted, its strobe never fires
    assign O_SPARE_ADAPTER_SELECT = 1'b0;
    assign O_PROG_ADDR = prog_addr_reg;

    // Act once per transfer, on the first enable cycle
    assign access = bus.e && !e_q_reg && bus.valid_address_qualifier;
    assign rd_access = access && bus.rw;
    assign wr_access = access && !bus.rw;

    // Enable edge detect and program memory address
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            e_q_reg <= 1'b0;
            prog_addr_reg <= 13'h0000;
        end else begin
            e_q_reg <= bus.e;
            prog_addr_reg <= bus.addr[12:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data, held until the next read
    assign bus.rdata = rdata_reg;
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            rdata_reg <= 8'h00;
        end else if (rd_access) begin
            if (sel[0]) begin
                rdata_reg <= I_PROG_DATA;
            end else if (sel[1]) begin
                if (func == `GCB_CTL_STATUS) begin
                    rdata_reg <= {3'h0, seq_reg, irq_reg, I_REMOTE, !fifo_in_ready, fifo_out_valid};
                end else if (func == `GCB_CTL_DATA) begin
                    rdata_reg <= fifo_out_data;
                end else begin
                    rdata_reg <= 8'h00;
                end
            end else if (sel[2]) begin
                if (func == `GCB_PA_DATA_LO) begin
                    rdata_reg <= pa_read[7:0];
                end else if (func == `GCB_PA_DATA_HI) begin
                    rdata_reg <= pa_read[15:8];
                end else if (func == `GCB_PA_DIR_LO) begin
                    rdata_reg <= pa_dir_reg[7:0];
                end else if (func == `GCB_PA_DIR_HI) begin
                    rdata_reg <= pa_dir_reg[15:8];
                end else begin
                    rdata_reg <= 8'h00;
                end
            end else begin
                rdata_reg <= `GCB_UNMAPPED_DATA;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Listener handshake; RFD waits on FIFO room, so a full FIFO stalls the talker
    assign O_RFD = hs_reg == HS_READY && fifo_in_ready;
    assign O_DAC = hs_reg == HS_ACCEPT;
    assign fifo_in_valid = hs_reg == HS_READY && I_DAV;
    assign push = fifo_in_valid && fifo_in_ready;

    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            hs_reg <= HS_READY;
        end else begin
            case (hs_reg)
                HS_READY: begin
                    if (push) begin
                        hs_reg <= HS_ACCEPT;
                    end
                end
                HS_ACCEPT: begin
                    if (!I_DAV) begin
                        hs_reg <= HS_RELEASE;
                    end
                end
                HS_RELEASE: begin
                    hs_reg <= HS_READY;
                end
                default: begin
                    hs_reg <= HS_READY;
                end
            endcase
        end
    end

    // Received bytes wait here until the processor reads the data function
    assign fifo_pop = rd_access && sel[1] && func == `GCB_CTL_DATA;
    gcb_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(I_CLK),
        .i_rst_n(I_RST_N),
        .i_in_valid(fifo_in_valid),
        .o_in_ready(fifo_in_ready),
        .i_in_data(I_DIO),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(fifo_pop),
        .o_out_data(fifo_out_data)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Service request: only the byte that opens a sequence, or a remote/local change
    assign irq_set = (push && !seq_reg) || (I_REMOTE != remote_q_reg);
    assign irq_ack = wr_access && sel[1] && func == `GCB_CTL_ACK && bus.wdata[0];
    assign bus.irq_n = !irq_reg;
    assign O_IRQ_LAMP = irq_reg;

    // Sequence ends with the byte flagged as last
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            seq_reg <= 1'b0;
            remote_q_reg <= 1'b0;
        end else begin
            remote_q_reg <= I_REMOTE;
            if (push) begin
                seq_reg <= !I_EOI;
            end
        end
    end

    // A new request in the acknowledge cycle wins over the clear
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            irq_reg <= 1'b0;
        end else if (irq_set) begin
            irq_reg <= 1'b1;
        end else if (irq_ack) begin
            irq_reg <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Parallel adapter: direction and output registers written byte-wise
    always_ff @(posedge I_CLK or negedge I_RST_N) begin
        if (!I_RST_N) begin
            pa_out_reg <= `GCB_PA_OUT_RST;
            pa_dir_reg <= `GCB_PA_DIR_RST;
        end else if (wr_access && sel[2]) begin
            if (func == `GCB_PA_DATA_LO) begin
                pa_out_reg[7:0] <= bus.wdata;
            end else if (func == `GCB_PA_DATA_HI) begin
                pa_out_reg[15:8] <= bus.wdata;
            end else if (func == `GCB_PA_DIR_LO) begin
                pa_dir_reg[7:0] <= bus.wdata;
            end else if (func == `GCB_PA_DIR_HI) begin
                pa_dir_reg[15:8] <= bus.wdata;
            end
        end
    end

    // Pin levels seen by the adapter; undriven output lines float high
    always_comb begin
        pa_pins = 16'hffff;
        pa_pins[`GCB_PA_SYN_LSB +: 4] = I_SYNTH_ADDR;
        pa_pins[`GCB_PA_LOCK] = I_LOOP_LOCK;
        pa_pins[`GCB_PA_LEVELED] = I_LEVELED;
    end

    // Each line reads its output latch if driven, else the pin
    for (genvar i = 0; i < 16; i++) begin : g_pa_read
        assign pa_read[i] = pa_dir_reg[i] ? pa_out_reg[i] : pa_pins[i];
    end

    // Only lines set as outputs drive the instrument; others idle high
    assign O_TRANSFER_WINDOW = pa_read[`GCB_PA_WINDOW];
    assign O_SPARE_OUT = pa_read[`GCB_PA_SPARE];
    assign O_FREQ_DATA = pa_read[`GCB_PA_FREQ_LSB +: 4];
    assign O_LEVEL_DATA = pa_read[`GCB_PA_LEVEL_LSB +: 4];
endmodule

// ==== bench/gcb_board_chk.sv ====
// Checks on bus, strobes, handshake and interrupt
`timescale 1ns/1ps
`include "gcb_defines.svh"
module gcb_board_chk (
    input wire logic I_CLK,
    input wire logic I_RST_N,
    input wire logic [15:0] addr,
    input wire logic rw,
    input wire logic e,
    input wire logic qual,
    input wire logic irq_n,
    input wire logic prog_sel,
    input wire logic ctl_sel,
    input wire logic pa_sel,
    input wire logic spare_sel,
    input wire logic [12:0] prog_addr,
    input wire logic dav,
    input wire logic remote,
    input wire logic rfd,
    input wire logic dac,
    input wire logic lamp
);
    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (!I_RST_N);
    wire [3:0] sel = {prog_sel, ctl_sel, pa_sel, spare_sel};
    ////////////////////////////////////////
    // Handshake steps: byte taken, accepted, released
    sequence take_s; rfd && dav; endsequence
    sequence accept_s; dac && !rfd; endsequence
    sequence release_s; !dac && !rfd; endsequence
    ////////////////////////////////////////
    // Decoder strobes; qual is the valid-address qualifier
    one_strobe_a: assert property ($onehot0(sel))
        else $error("more than one strobe active");
    qual_gate_a: assert property (!qual |-> sel == 4'h0)
        else $error("strobe without valid address");
    spare_idle_a: assert property (!spare_sel)
        else $error("spare strobe active");
    prog_decode_a: assert property (prog_sel == (qual && addr[15:13] == `GCB_REGION_PROGRAM))
        else $error("program strobe wrong");
    ctl_decode_a: assert property (ctl_sel == (qual && addr[15:13] == `GCB_REGION_BUS_CTRL))
        else $error("controller strobe wrong");
    pa_decode_a: assert property (pa_sel == (qual && addr[15:13] == `GCB_REGION_ADAPTER))
        else $error("adapter strobe wrong");
    // Program address lags the bus by one cycle
    prog_addr_a: assert property (1'b1 |=> prog_addr == $past(addr[12:0]))
        else $error("program address lag wrong");
    // Enable only rises on a settled, qualified cycle
    enable_settle_a: assert property ($rose(e) |-> qual && $stable(addr) && $stable(rw))
        else $error("enable rose on unsettled cycle");
    take_ack_a: assert property (take_s |=> accept_s)
        else $error("byte taken without accept");
    dac_hold_a: assert property (accept_s ##0 dav |=> dac)
        else $error("accept dropped while data valid");
    dac_drop_a: assert property (accept_s ##0 !dav |=> release_s)
        else $error("accept not released");
    lamp_irq_a: assert property (lamp == !irq_n)
        else $error("lamp differs from interrupt");
    remote_irq_a: assert property ($changed(remote) |-> ##[1:3] !irq_n)
        else $error("no interrupt on remote change");
endmodule

// ==== bench/tb_gpib_control_board_logic.sv ====
// Bench: processor end and board logic on one bus
`timescale 1ns/1ps
`include "gcb_defines.svh"
module tb_gpib_control_board_logic;
    import gcb_pkg::*;
    logic I_CLK = 1'b0;
    logic I_RST_N = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr;
    gcb_byte_t dio = 8'h00;
    logic dav = 1'b0, eoi = 1'b0, remote = 1'b0;
    logic [3:0] syn = 4'h0;
    logic lock = 1'b0, leveled = 1'b0;
    logic sel_prog, sel_ctl, sel_pa, sel_spare, rfd, dac, lamp, window, spare_out;
    logic [12:0] prog_addr;
    logic [3:0] freq, level;
    gcb_byte_t q;
    int bad_count = 0, checked = 0;
    // Program memory model
    wire gcb_byte_t prog_data = prog_addr[7:0] ^ 8'h3c;
    gcb_proc_if bus_if();
    gcb_processor_end gcb_processor_end_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(psel),
        .I_PENABLE(penable), .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .bus(bus_if));
    gcb_board gcb_board_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .bus(bus_if), .O_PROGRAM_MEMORY_SELECT(sel_prog),
        .O_BUS_CONTROLLER_SELECT(sel_ctl), .O_PARALLEL_ADAPTER_SELECT(sel_pa), .O_SPARE_ADAPTER_SELECT(sel_spare),
        .O_PROG_ADDR(prog_addr), .I_PROG_DATA(prog_data), .I_DIO(dio), .I_DAV(dav), .I_EOI(eoi), .I_REMOTE(remote),
        .O_RFD(rfd), .O_DAC(dac), .O_IRQ_LAMP(lamp), .I_SYNTH_ADDR(syn), .I_LOOP_LOCK(lock), .I_LEVELED(leveled),
        .O_TRANSFER_WINDOW(window), .O_SPARE_OUT(spare_out), .O_FREQ_DATA(freq), .O_LEVEL_DATA(level));
    gcb_board_chk gcb_board_chk_inst (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .addr(bus_if.addr), .rw(bus_if.rw),
        .e(bus_if.e), .qual(bus_if.valid_address_qualifier), .irq_n(bus_if.irq_n), .prog_sel(sel_prog),
        .ctl_sel(sel_ctl), .pa_sel(sel_pa), .spare_sel(sel_spare), .prog_addr(prog_addr), .dav(dav),
        .remote(remote), .rfd(rfd), .dac(dac), .lamp(lamp));
    // 125 MHz clock
    initial begin
        forever #4 I_CLK = ~I_CLK;
    end
    ////////////////////////////////////////
    task finish_test;
        $display("Comparisons %0d, mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s: expected %h, seen %h", name, exp, seen);
        end
    endtask
    // A timed-out wait ends the run
    task guard(input int n);
        if (n >= 50) begin
            check("wait", n, 0);
            finish_test();
        end
    endtask
    // One APB transfer, held until pready is seen
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge I_CLK);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge I_CLK);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (pready !== 1'b1 && n < 50);
        guard(n);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // One processor-bus cycle, then its result
    task acc(input gcb_addr_t a, input logic rd, input gcb_byte_t wd, output gcb_byte_t r);
        logic [31:0] v;
        logic err;
        int n;
        apb(1'b1, `GCB_REG_ADDR, {16'h0, a}, v, err);
        apb(1'b1, `GCB_REG_WDATA, {24'h0, wd}, v, err);
        apb(1'b1, `GCB_REG_CTRL, {30'h0, rd, 1'b1}, v, err);
        n = 0;
        do begin
            apb(1'b0, `GCB_REG_STATUS, 32'h0, v, err);
            n++;
        end while (v[0] !== 1'b0 && n < 50);
        guard(n);
        apb(1'b0, `GCB_REG_RDATA, 32'h0, v, err);
        r = v[7:0];
    endtask
    // Talker side of the handshake
    task send(input gcb_byte_t b, input logic last);
        int n;
        n = 0;
        while (rfd !== 1'b1 && n < 50) begin
            @(posedge I_CLK);
            n++;
        end
        guard(n);
        dio <= b;
        eoi <= last;
        dav <= 1'b1;
        n = 0;
        do begin
            @(posedge I_CLK);
            n++;
        end while (dac !== 1'b1 && n < 50);
        guard(n);
        dav <= 1'b0;
        dio <= ~b;
    endtask
    ////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] v;
        logic err;
        repeat (12) @(posedge I_CLK);
        I_RST_N <= 1'b1;
        syn <= 4'h9;
        lock <= 1'b1;
        apb(1'b0, 12'h020, 32'h0, v, err);
        check("apb_unmapped_err", err, 1'b1);
        check("apb_unmapped_rd", v, 32'h0);
        check("window_reset", window, 1'b1);
        acc(16'ha002, 1'b0, 8'hc0, q);
        acc(16'ha003, 1'b0, 8'hff, q);
        acc(16'ha001, 1'b0, 8'h5a, q);
        check("freq", freq, 4'ha);
        check("level", level, 4'h5);
        acc(16'ha000, 1'b0, 8'h80, q);
        check("window_low", window, 1'b0);
        check("spare_out", spare_out, 1'b1);
        acc(16'ha000, 1'b1, 8'h00, q);
        check("adapter_inputs", q, 8'h99);
        acc(16'hbff8, 1'b1, 8'h00, q);
        check("adapter_low_bits", q, 8'h99);
        acc(16'ha000, 1'b0, 8'h40, q);
        check("window_high", window, 1'b1);
        acc(16'he123, 1'b1, 8'h00, q);
        check("program_read", q, 8'h1f);
        for (int i = 0; i < 7; i++) begin
            if (i < 4 || i == 6) begin
                acc({i[2:0], 13'h0004}, 1'b1, 8'h00, q);
                check("unmapped_read", q, 8'hff);
            end
        end
        send(8'h40, 1'b0);
        repeat (2) @(posedge I_CLK);
        check("irq_first", bus_if.irq_n, 1'b0);
        check("irq_lamp", lamp, 1'b1);
        acc(16'h8002, 1'b0, 8'h01, q);
        check("irq_ack", bus_if.irq_n, 1'b1);
        for (int i = 1; i < 16; i++) begin
            send(gcb_byte_t'(64 + i), i == 15);
        end
        repeat (3) @(posedge I_CLK);
        check("irq_in_sequence", lamp, 1'b0);
        check("rfd_full", rfd, 1'b0);
        for (int i = 0; i < 16; i++) begin
            acc(16'h8001, 1'b1, 8'h00, q);
            check("fifo_data", q, 64 + i);
        end
        acc(16'h8000, 1'b1, 8'h00, q);
        check("fifo_empty", q[`GCB_ST_AVAIL], 1'b0);
        check("rfd_ready", rfd, 1'b1);
        remote <= 1'b1;
        repeat (4) @(posedge I_CLK);
        check("irq_remote", lamp, 1'b1);
        acc(16'h8002, 1'b0, 8'h01, q);
        check("irq_cleared", lamp, 1'b0);
        finish_test();
    end
endmodule
